/* core/eirh_pkg.sv */
// package for the edge interrupt and run/halt control block
// assumes a single 25 MHz clock; all constants and carrier types live here
package eirh_pkg;
	// clock and timing
	localparam int CLOCK_HZ = 25_000_000;
	localparam int REACT_MAX_US = 1000; // ack deadline after a dispatch is raised, in microseconds
	localparam int REACT_MAX_CYCLES = (CLOCK_HZ / 1_000_000) * REACT_MAX_US;
	localparam int CNT_W = 15;
	// handler numbers
	localparam logic [7:0] HANDLER_FALLBACK = 8'h00;
	localparam logic [7:0] HANDLER_TWO_FIRST = 8'h14; // handler 20
	localparam logic [7:0] HANDLER_TWO_SECOND = 8'h19; // handler 25
	localparam logic [7:0] HANDLER_FOUR_BASE = 8'h14; // handlers 20..23
	// system and io addresses (decimal 8000, 8100..8105)
	localparam logic [15:0] ADDR_HALT_DIAG = 16'h1f40;
	localparam logic [15:0] ADDR_IN_BASE = 16'h1fa4;
	localparam logic [15:0] ADDR_OUT_A = 16'h1fa8;
	localparam logic [15:0] ADDR_OUT_B = 16'h1fa9;
	localparam int BIT_HALT_RELEASED = 0;
	localparam int N_LINES = 4;
	// variant select
	typedef enum logic [0:0] {
		EIRH_VAR_TWO = 1'b0,
		EIRH_VAR_FOUR = 1'b1
	} eirh_variant_t;
	// operating state
	typedef enum logic [1:0] {
		EIRH_ST_BOOT = 2'b00,
		EIRH_ST_RUN = 2'b01,
		EIRH_ST_HALT = 2'b10,
		EIRH_ST_COLD = 2'b11
	} eirh_state_t;
	// dispatch request to the cpu
	typedef struct packed {
		logic valid;
		logic error_led;
		logic [7:0] handler;
	} eirh_dispatch_t;
	// cpu io access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic wdata;
	} eirh_io_req_t;
endpackage

/* core/eirh_edge_detect.sv */
// rising edge detector for the interrupt lines
// assumes inputs already synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module eirh_edge_detect (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// lines
	input wire logic [eirh_pkg::N_LINES-1:0] line_in,
	output logic [eirh_pkg::N_LINES-1:0] line_level,
	output logic [eirh_pkg::N_LINES-1:0] line_rise
);
	// state: registered level and one-cycle rise pulse
	typedef struct packed {
		logic [eirh_pkg::N_LINES-1:0] prev;
		logic [eirh_pkg::N_LINES-1:0] rise;
	} eirh_edge_state_t;
	eirh_edge_state_t st;
	eirh_edge_state_t next_st;
	// one pulse per low-to-high transition, per line
	always_comb begin
		next_st = st;
		next_st.prev = line_in;
		for (int i = 0; i < eirh_pkg::N_LINES; i++) begin
			next_st.rise[i] = line_in[i] & ~st.prev[i];
		end
	end
	// register the state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign line_level = st.prev;
	assign line_rise = st.rise;
endmodule
`default_nettype wire

/* core/eirh_runhalt.sv */
// run/halt state machine: front switch, jumper and start-up halt button
// assumes switch and button inputs synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module eirh_runhalt (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// controls
	input wire logic switch_enable_jumper,
	input wire logic run_switch,
	input wire logic halt_button_n,
	// status
	output eirh_pkg::eirh_state_t run_state,
	output logic cold_start
);
	// state record
	typedef struct packed {
		eirh_pkg::eirh_state_t state;
		logic sw_prev;
		logic sw_seen;
		logic cold;
	} eirh_rh_state_t;
	eirh_rh_state_t st;
	eirh_rh_state_t next_st;
	// next state; the switch acts on its transitions only
	always_comb begin
		next_st = st;
		next_st.cold = 1'b0;
		next_st.sw_prev = run_switch;
		next_st.sw_seen = 1'b1;
		unique case (st.state)
			eirh_pkg::EIRH_ST_BOOT: begin
				// button held at start-up keeps us halted until a reset or an enabled run-switch edge
				if (!halt_button_n) begin
					next_st.state = eirh_pkg::EIRH_ST_HALT;
				end else begin
					next_st.state = eirh_pkg::EIRH_ST_COLD;
				end
			end
			eirh_pkg::EIRH_ST_COLD: begin
				next_st.cold = 1'b1;
				next_st.state = eirh_pkg::EIRH_ST_RUN;
			end
			eirh_pkg::EIRH_ST_RUN: begin
				if (switch_enable_jumper && st.sw_seen && st.sw_prev && !run_switch) begin
					next_st.state = eirh_pkg::EIRH_ST_HALT;
				end
			end
			eirh_pkg::EIRH_ST_HALT: begin
				// run edge restarts cold, never a plain resume
				if (switch_enable_jumper && st.sw_seen && !st.sw_prev && run_switch) begin
					next_st.state = eirh_pkg::EIRH_ST_COLD;
				end
			end
		endcase
	end
	// register the state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '{eirh_pkg::EIRH_ST_BOOT, 1'b0, 1'b0, 1'b0};
		end else begin
			st <= next_st;
		end
	end
	assign run_state = st.state;
	assign cold_start = st.cold;
endmodule
`default_nettype wire

/* core/eirh_top.sv */
// edge interrupt dispatch and run/halt control
// assumes the cpu takes a dispatch when dispatch_ack is high and inputs are synchronous
`timescale 1ns/1ps
`default_nettype none
module eirh_top (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// configuration
	input wire eirh_pkg::eirh_variant_t variant,
	input wire logic [eirh_pkg::N_LINES-1:0] handler_present,
	input wire logic fallback_to_handler0,
	// field inputs
	input wire logic [eirh_pkg::N_LINES-1:0] irq_line,
	input wire logic switch_enable_jumper,
	input wire logic run_switch,
	input wire logic halt_button_n,
	// cpu side
	input wire eirh_pkg::eirh_io_req_t io_req,
	input wire logic dispatch_ack,
	output eirh_pkg::eirh_dispatch_t dispatch,
	output logic [31:0] io_rdata,
	output logic io_rvalid,
	output logic deadline_miss,
	// field outputs and status
	output logic general_output_a,
	output logic general_output_b,
	output eirh_pkg::eirh_state_t run_state,
	output logic cold_start
);
	logic [eirh_pkg::N_LINES-1:0] lvl;
	logic [eirh_pkg::N_LINES-1:0] rise;
	eirh_pkg::eirh_state_t rh_state;
	logic rh_cold;
	// edge detection per line
	eirh_edge_detect u_edge (
		.clock(clock),
		.resetn(resetn),
		.line_in(irq_line),
		.line_level(lvl),
		.line_rise(rise)
	);
	// run/halt control
	eirh_runhalt u_rh (
		.clock(clock),
		.resetn(resetn),
		.switch_enable_jumper(switch_enable_jumper),
		.run_switch(run_switch),
		.halt_button_n(halt_button_n),
		.run_state(rh_state),
		.cold_start(rh_cold)
	);
	// all state of the top in one record
	typedef struct packed {
		logic [eirh_pkg::N_LINES-1:0] pend;
		logic [eirh_pkg::CNT_W-1:0] age;
		eirh_pkg::eirh_dispatch_t disp;
		logic [31:0] rdata;
		logic rvalid;
		logic miss;
		logic out_a;
		logic out_b;
		eirh_pkg::eirh_state_t rs;
		logic cold;
	} eirh_top_state_t;
	eirh_top_state_t st;
	eirh_top_state_t next_st;
	logic [eirh_pkg::N_LINES-1:0] active;
	logic [eirh_pkg::N_LINES-1:0] pend_now;
	logic [1:0] sel;
	logic sel_ok;
	logic miss_set; // deadline event this cycle, so a cold start cannot hide it
	// which lines can raise interrupts in the chosen variant
	always_comb begin
		if (variant == eirh_pkg::EIRH_VAR_TWO) begin
			active = 4'h3;
		end else begin
			active = 4'hf;
		end
	end
	// fixed priority pick over pending lines, lowest index first
	always_comb begin
		pend_now = st.pend;
		sel = 2'd0;
		sel_ok = 1'b0;
		for (int i = eirh_pkg::N_LINES - 1; i >= 0; i--) begin
			if (pend_now[i]) begin
				sel = 2'(i);
				sel_ok = 1'b1;
			end
		end
	end
	// dispatch, io and status
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		next_st.rs = rh_state;
		next_st.cold = rh_cold;
		miss_set = 1'b0;
		// a dispatch slot frees when taken; a new edge sets pending, winning over clear
		if (st.disp.valid && dispatch_ack) begin
			next_st.disp = '0;
		end else if (!st.disp.valid) begin
			// the error lamp is a one-slot pulse, not a latch
			next_st.disp.error_led = 1'b0;
		end
		if (next_st.disp.valid == 1'b0 && sel_ok && rh_state == eirh_pkg::EIRH_ST_RUN) begin
			next_st.pend[sel] = 1'b0;
			next_st.disp.valid = 1'b1;
			next_st.disp.error_led = 1'b0;
			if (variant == eirh_pkg::EIRH_VAR_TWO) begin
				next_st.disp.handler = (sel == 2'd0) ? eirh_pkg::HANDLER_TWO_FIRST
					: eirh_pkg::HANDLER_TWO_SECOND;
				if (!handler_present[sel]) begin
					// unprogrammed: lamp, or the fallback handler when selected
					next_st.disp.handler = eirh_pkg::HANDLER_FALLBACK;
					next_st.disp.valid = fallback_to_handler0;
					next_st.disp.error_led = !fallback_to_handler0;
				end
			end else begin
				next_st.disp.handler = eirh_pkg::HANDLER_FOUR_BASE + 8'(sel);
			end
			next_st.age = '0;
		end else if (st.disp.valid && !(dispatch_ack)) begin
			// deadline watch; an ack within REACT_MAX_CYCLES of the dispatch keeps this from tripping
			if (st.age >= eirh_pkg::CNT_W'(eirh_pkg::REACT_MAX_CYCLES - 1)) begin
				next_st.miss = 1'b1;
				miss_set = 1'b1;
			end else begin
				next_st.age = st.age + 1'b1;
			end
		end
		for (int i = 0; i < eirh_pkg::N_LINES; i++) begin
			// four-input lines with no handler are plain inputs, not interrupts
			if (rise[i] && active[i]
				&& (variant == eirh_pkg::EIRH_VAR_TWO || handler_present[i])) begin
				next_st.pend[i] = 1'b1;
			end
		end
		// io reads
		if (io_req.rd) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = '0;
			if (io_req.addr == eirh_pkg::ADDR_HALT_DIAG) begin
				next_st.rdata[eirh_pkg::BIT_HALT_RELEASED] = halt_button_n;
			end else if (variant == eirh_pkg::EIRH_VAR_FOUR
				&& io_req.addr >= eirh_pkg::ADDR_IN_BASE
				&& io_req.addr < eirh_pkg::ADDR_IN_BASE + 16'h0004) begin
				next_st.rdata[0] = lvl[2'(io_req.addr - eirh_pkg::ADDR_IN_BASE)];
			end else if (io_req.addr == eirh_pkg::ADDR_OUT_A) begin
				next_st.rdata[0] = st.out_a;
			end else if (io_req.addr == eirh_pkg::ADDR_OUT_B) begin
				next_st.rdata[0] = st.out_b;
			end
		end
		// io writes to the two general outputs
		if (io_req.wr && variant == eirh_pkg::EIRH_VAR_FOUR) begin
			if (io_req.addr == eirh_pkg::ADDR_OUT_A) begin
				next_st.out_a = io_req.wdata;
			end else if (io_req.addr == eirh_pkg::ADDR_OUT_B) begin
				next_st.out_b = io_req.wdata;
			end
		end
		// a cold start drops stale requests and clears the miss flag
		if (rh_cold) begin
			next_st.pend = '0;
			// a miss in the same cycle as the clear wins
			next_st.miss = miss_set;
		end
	end
	// register the state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	// outputs straight from flops
	assign dispatch = st.disp;
	assign io_rdata = st.rdata;
	assign io_rvalid = st.rvalid;
	assign deadline_miss = st.miss;
	assign general_output_a = st.out_a;
	assign general_output_b = st.out_b;
	assign run_state = st.rs;
	assign cold_start = st.cold;
endmodule
`default_nettype wire

/* tb/eirh_monitor.sv */
// port checker for eirh_top: dispatch, io reads and writes, run/halt states
// assumes a bind onto eirh_top with one clock and an active-low reset
`timescale 1ns/1ps
`default_nettype none
module eirh_monitor (
	// clock, reset and single-bit controls
	input wire logic clock, resetn, fallback_to_handler0, switch_enable_jumper,
	input wire logic run_switch, halt_button_n, dispatch_ack, io_rvalid,
	input wire logic general_output_a, cold_start,
	// buses and carriers
	input wire eirh_pkg::eirh_variant_t variant,
	input wire logic [3:0] handler_present, irq_line,
	input wire eirh_pkg::eirh_io_req_t io_req,
	input wire eirh_pkg::eirh_dispatch_t dispatch,
	input wire logic [31:0] io_rdata,
	input wire eirh_pkg::eirh_state_t run_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_hold; dispatch.valid && !dispatch_ack |=> dispatch.valid && $stable(dispatch.handler); endproperty
	a_hold: assert property (p_hold) else $error("dispatch dropped before ack");
	property p_two; dispatch.valid && !variant |-> dispatch.handler inside {8'h14, 8'h19}
		|| (fallback_to_handler0 && dispatch.handler == 8'h00); endproperty
	a_two: assert property (p_two) else $error("bad two-input handler");
	property p_fast; $rose(irq_line[0]) && run_state == 2'b01 && !dispatch.valid && variant
		&& handler_present[0] |-> ##[1:3] dispatch.valid && dispatch.handler == 8'h14; endproperty
	a_fast: assert property (p_fast) else $error("line 0 not dispatched in time");
	property p_led; dispatch.error_led |-> !variant && !fallback_to_handler0; endproperty
	a_led: assert property (p_led) else $error("error lamp out of place");
	property p_diag; io_req.rd && io_req.addr == 16'h1f40 |=> io_rvalid
		&& io_rdata == {31'h0000_0000, $past(halt_button_n)}; endproperty
	a_diag: assert property (p_diag) else $error("diagnostic read wrong");
	property p_outa; variant && io_req.wr && io_req.addr == 16'h1fa8
		|=> general_output_a == $past(io_req.wdata); endproperty
	a_outa: assert property (p_outa) else $error("output a not written");
	property p_halt; switch_enable_jumper && run_state == 2'b01 && $fell(run_switch)
		|-> ##[1:4] run_state == 2'b10; endproperty
	a_halt: assert property (p_halt) else $error("switch did not halt");
	property p_cold; switch_enable_jumper && run_state == 2'b10 && $rose(run_switch)
		|-> ##[1:5] cold_start; endproperty
	a_cold: assert property (p_cold) else $error("switch did not cold start");
	property p_keep; !switch_enable_jumper && run_state inside {2'b01, 2'b10}
		|=> run_state == $past(run_state); endproperty
	a_keep: assert property (p_keep) else $error("state moved without switch");
	property p_boot; run_state == 2'b00 && !halt_button_n |-> ##2 run_state == 2'b10; endproperty
	a_boot: assert property (p_boot) else $error("pressed button did not hold halt");
endmodule
bind eirh_top eirh_monitor eirh_monitor_inst (.clock, .resetn, .fallback_to_handler0,
	.switch_enable_jumper, .run_switch, .halt_button_n, .dispatch_ack, .io_rvalid,
	.general_output_a, .cold_start, .variant, .handler_present, .irq_line, .io_req,
	.dispatch, .io_rdata, .run_state);
`default_nettype wire

/* tb/eirh_field_model.sv */
// field-side model: interrupt pulses from the plant
// assumes one-cycle fire requests driven away from the rising edge
`timescale 1ns/1ps
`default_nettype none
module eirh_field_model #(
	parameter int HALF = 12500 // half period at 1 kHz; shortened in simulation
) (
	// clock
	input wire logic clock,
	// pulse requests and lines
	input wire logic [3:0] fire,
	output logic [3:0] irq_line,
	output logic busy
);
	int cnt = 0;
	initial irq_line = 4'h0;
	assign busy = cnt != 0;
	// one pulse at a time keeps the combined rate within one period
	always @(posedge clock) begin
		if (!busy && fire != 4'h0) begin
			irq_line <= fire;
			cnt <= 2 * HALF;
		end else if (busy) begin
			cnt <= cnt - 1;
			if (cnt == HALF + 1) irq_line <= 4'h0; // equal high and low times
		end
	end
endmodule
`default_nettype wire

/* tb/eirh_tb.sv */
// self-checking bench for eirh_top with the field model
// assumes the design's run state is reached a few cycles after reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %0h got %0h", n, e, g); end end
module edge_interrupt_and_run_halt_control_tb;
	logic clock = 0, resetn = 0, fallback_to_handler0 = 0, switch_enable_jumper = 0;
	logic run_switch = 1, halt_button_n = 1, dispatch_ack = 0, d;
	logic io_rvalid, deadline_miss, general_output_a, general_output_b, cold_start, busy;
	logic [3:0] handler_present = 4'hf, fire = 4'h0, irq_line;
	logic [31:0] io_rdata;
	eirh_pkg::eirh_variant_t variant = eirh_pkg::EIRH_VAR_TWO;
	eirh_pkg::eirh_io_req_t io_req = '0;
	eirh_pkg::eirh_dispatch_t dispatch;
	eirh_pkg::eirh_state_t run_state;
	int fails = 0, total_checks = 0, cyc = 0, seed = 32'h9dc9, k;
	eirh_top eirh_top_inst (.clock, .resetn, .variant, .handler_present, .fallback_to_handler0,
		.irq_line, .switch_enable_jumper, .run_switch, .halt_button_n, .io_req, .dispatch_ack,
		.dispatch, .io_rdata, .io_rvalid, .deadline_miss, .general_output_a, .general_output_b,
		.run_state, .cold_start);
	eirh_field_model #(.HALF(20)) eirh_field_model_inst (.clock, .fire, .irq_line, .busy);
	initial forever #20 clock = ~clock;
	// hang guard well above the several hundred cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic tick(int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic rst(logic b);
		resetn = 0;
		halt_button_n = b;
		tick(20);
		resetn = 1;
		tick(10);
	endtask
	task automatic rd(logic [15:0] a, logic [31:0] e);
		io_req = '{1'b1, 1'b0, a, 1'b0};
		tick(1);
		io_req = '0;
		for (int i = 0; i < 3 && io_rvalid !== 1'b1; i++) tick(1);
		`CHK("rdata", e, io_rdata)
	endtask
	task automatic wr(logic [15:0] a, logic v);
		io_req = '{1'b0, 1'b1, a, v};
		tick(1);
		io_req = '0;
		tick(1);
	endtask
	task automatic pulse(int i);
		while (busy) tick(1);
		fire = 4'(4'h1 << i);
		tick(1);
		fire = 4'h0;
	endtask
	task automatic take(logic [7:0] h, logic e);
		int n;
		n = 0;
		while (dispatch.valid !== 1'b1 && dispatch.error_led !== 1'b1 && n < 200) begin
			n++;
			tick(1);
		end
		`CHK("error_led", e, dispatch.error_led)
		if (!e) begin
			`CHK("handler", h, dispatch.handler)
			dispatch_ack = 1;
			tick(1);
			dispatch_ack = 0;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		rst(0);
		`CHK("state", eirh_pkg::EIRH_ST_HALT, run_state)
		rd(16'h1f40, 32'h0000_0000);
		halt_button_n = 1;
		tick(50);
		`CHK("state", eirh_pkg::EIRH_ST_HALT, run_state)
		rst(1);
		`CHK("state", eirh_pkg::EIRH_ST_RUN, run_state)
		rd(16'h1f40, 32'h0000_0001);
		$display("start-up test done");
		pulse(0);
		take(8'h14, 0);
		pulse(1);
		take(8'h19, 0);
		handler_present = 4'h1;
		fallback_to_handler0 = 1;
		pulse(1);
		take(8'h00, 0);
		fallback_to_handler0 = 0;
		pulse(1);
		take(8'h00, 1);
		rd(16'h1fa4, 32'h0000_0000);
		$display("two-input test done");
		variant = eirh_pkg::EIRH_VAR_FOUR;
		handler_present = 4'hf;
		rst(1);
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			take(8'(8'h14 + i), 0);
		end
		repeat (6) begin
			k = $random(seed) & 3;
			pulse(k);
			take(8'(8'h14 + k), 0);
		end
		handler_present = 4'h0;
		pulse(2);
		tick(6);
		rd(16'h1fa6, 32'h0000_0001);
		tick(45);
		rd(16'h1fa6, 32'h0000_0000);
		`CHK("valid", 1'b0, dispatch.valid)
		d = 1'($random(seed));
		wr(16'h1fa8, d);
		`CHK("out_a", d, general_output_a)
		wr(16'h1fa9, ~d);
		`CHK("out_b", ~d, general_output_b)
		rd(16'h1f41, 32'h0000_0000);
		$display("four-input test done");
		run_switch = 0;
		tick(5);
		`CHK("state", eirh_pkg::EIRH_ST_RUN, run_state)
		run_switch = 1;
		switch_enable_jumper = 1;
		tick(2);
		run_switch = 0;
		tick(5);
		`CHK("state", eirh_pkg::EIRH_ST_HALT, run_state)
		run_switch = 1;
		for (int i = 0; i < 10 && cold_start !== 1'b1; i++) tick(1);
		`CHK("cold_start", 1'b1, cold_start)
		tick(5);
		`CHK("state", eirh_pkg::EIRH_ST_RUN, run_state)
		`CHK("miss", 1'b0, deadline_miss)
		$display("switch test done");
		wrap_up();
	end
endmodule
`default_nettype wire
